// file: inc/scs_pkg.sv
// constants and types for the system clock source selector
// assumes a 20 MHz mclk and a separate free running watchdog oscillator
package scs_pkg;

   // ****************************************
   // clock source select codes
   // ****************************************
   localparam logic [3:0] CSRC_EXT    = 4'h0;
   localparam logic [3:0] CSRC_RC1    = 4'h1;
   localparam logic [3:0] CSRC_RC8    = 4'h4;
   localparam logic       PLLSEL_PLL  = 1'b0;
   localparam logic [1:0] STUP_NONE   = 2'h0;
   localparam logic [1:0] STUP_SHORT  = 2'h1;
   localparam logic [1:0] STUP_LONG   = 2'h2;
   localparam logic [1:0] STUP_RSVD   = 2'h3;

   // ****************************************
   // timing
   // ****************************************
   localparam int MCLK_HZ           = 20000000;
   localparam int STARTUP_SHORT_CK  = 6;
   localparam int STARTUP_PLL_CK    = 1024;
   localparam int STARTUP_PLL16K_CK = 16384;
   localparam int T_DLY_SHORT_US    = 4100;
   localparam int T_DLY_LONG_US     = 65000;
   localparam int WDOG_OSC_KHZ      = 1000;
   localparam int PLL_MHZ           = 64;
   localparam int PLL_DIV           = 4;
   localparam int SYS_PLL_MHZ       = PLL_MHZ / PLL_DIV;
   localparam int CNT_W             = 20;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [11:0] ADDR_TRIM   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [7:0]  TRIM_RESET  = 8'h00;
   localparam int ST_SRC      = 0;
   localparam int ST_RATE     = 2;
   localparam int ST_PLLSEL   = 4;
   localparam int ST_STUP     = 5;
   localparam int ST_OSCOPT   = 7;
   localparam int ST_RSVD     = 8;
   localparam int ST_HOLD     = 9;
   localparam int ST_READY    = 10;
   localparam int ST_OPTWARN  = 11;
   localparam int ST_CSRC     = 12;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0]
   {
      SRC_RC    = 2'b00,
      SRC_EXT   = 2'b01,
      SRC_PLL   = 2'b10,
      SRC_OTHER = 2'b11
   } scs_src_t;

   typedef enum logic [2:0]
   {
      ST_INIT   = 3'b000,
      ST_RSTDLY = 3'b001,
      ST_RUNNING = 3'b010,
      ST_SLEEP  = 3'b011,
      ST_WAKE   = 3'b100
   } scs_state_t;

   typedef struct packed
   {
      logic       pllSystemClockSelect;
      logic [3:0] clockSourceSelect;
      logic [1:0] startupTimeSelect;
      logic       oscillatorOption;
   } scs_fuse_t;

endpackage : scs_pkg

// file: logic/scs_clock_select.sv
// system clock source selector: fuse decode, start-up sequencing, rc trim
// assumes fuses and calibration byte are static, same-domain levels;
// the osc input pin and the watchdog oscillator are asynchronous
//
// Overview of operation
// - source select 0001..0100 selects the rc oscillator at 1, 2, 4 or 8 MHz, 0001 by default.
// - with the rc source power-down start-up is 6 cycles and reset delay is none, 4.1 ms or 65 ms, 11 reserved.
// - every reset copies the 1 MHz calibration byte into the trim register.
// - the trim value sets the rc frequency, 00 lowest and ff highest.
// - the reset delay is timed from the watchdog oscillator even with the rc source.
// - with the rc source the two oscillator pins are released as port b bits 4 and 5.
// - the osc input pin clocks the system only with source select 0000 and pll select 1.
// - with the external clock start-up is 6 cycles and reset delay is none, 4.1 ms or 65 ms, 11 reserved.
// - pll select 0 runs the system from the 64 MHz pll divided by four, 16 MHz.
// - the pll output also serves the fast timer clock whatever the system source.
// - with the pll start-up is 1K cycles with none, 4.1 ms, 65 ms delay, or 16K cycles for 11.
`timescale 1ns/1ps
module scs_clock_select
#(
   parameter int STARTUP_LONG_CK = scs_pkg::STARTUP_PLL16K_CK,
   parameter int DLY_SHORT_TICKS = scs_pkg::T_DLY_SHORT_US * scs_pkg::WDOG_OSC_KHZ / 1000,
   parameter int DLY_LONG_TICKS  = scs_pkg::T_DLY_LONG_US * scs_pkg::WDOG_OSC_KHZ / 1000
)
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // nonvolatile configuration
   input  wire scs_pkg::scs_fuse_t fuseIn,
   input  wire logic [7:0]        calibByte,
   // oscillator and power
   input  wire logic              oscInputPin,
   input  wire logic              wdogOscClk,
   input  wire logic              sleepReq,
   input  wire logic              fastClkReq,
   // clock control outputs
   output scs_pkg::scs_src_t      clkSource,
   output logic [1:0]             rcRate,
   output logic [7:0]             trimValue,
   output logic                   oscPinsAsPort,
   output logic                   pllEnable,
   output logic                   pllSysClk,
   output logic                   extClkTick,
   output logic                   coreResetHold,
   output logic                   clkReady
);
   import scs_pkg::*;

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic scs_src_t srcOf(input scs_fuse_t f);
      scs_src_t s;
      s = SRC_OTHER;
      if (f.pllSystemClockSelect == PLLSEL_PLL)
         s = SRC_PLL;
      else if (f.clockSourceSelect == CSRC_EXT)
         s = SRC_EXT;
      else if (f.clockSourceSelect >= CSRC_RC1 && f.clockSourceSelect <= CSRC_RC8)
         s = SRC_RC;
      return s;
   endfunction : srcOf

   function automatic logic [CNT_W-1:0] delayOf(input scs_src_t s, input logic [1:0] stup);
      logic [CNT_W-1:0] d;
      d = '0;
      if (s != SRC_OTHER)
      begin
         // 11 gives no delay for every source; reserved for rc and external
         if (stup == STUP_SHORT)
            d = CNT_W'(DLY_SHORT_TICKS);
         else if (stup == STUP_LONG)
            d = CNT_W'(DLY_LONG_TICKS);
      end
      return d;
   endfunction : delayOf

   function automatic logic [CNT_W-1:0] startupOf(input scs_src_t s, input logic [1:0] stup);
      logic [CNT_W-1:0] c;
      c = CNT_W'(STARTUP_SHORT_CK);
      if (s == SRC_PLL)
      begin
         if (stup == STUP_RSVD)
            c = CNT_W'(STARTUP_LONG_CK);
         else
            c = CNT_W'(STARTUP_PLL_CK);
      end
      return c;
   endfunction : startupOf

   // ****************************************
   // synchronisers
   // ****************************************
   logic extSync1;
   logic extSync2;
   logic extPrev;
   logic wdSync1;
   logic wdSync2;
   logic wdPrev;
   logic wdEdge;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         extSync1 <= 1'b0;
         extSync2 <= 1'b0;
         extPrev  <= 1'b0;
         wdSync1  <= 1'b0;
         wdSync2  <= 1'b0;
         wdPrev   <= 1'b0;
      end
      else
      begin
         extSync1 <= oscInputPin;
         extSync2 <= extSync1;
         extPrev  <= extSync2;
         wdSync1  <= wdogOscClk;
         wdSync2  <= wdSync1;
         wdPrev   <= wdSync2;
      end
   end

   // the watchdog oscillator runs free with no idle level, so the first
   // counted edge after release may come up to one tick early
   assign wdEdge = wdSync2 & ~wdPrev;

   // ****************************************
   // configuration capture
   // ****************************************
   scs_state_t state;
   scs_fuse_t  cfg;

   // caught once after release, so the source never switches in operation
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg       <= '0;
         clkSource <= SRC_RC;
      end
      else if (state == ST_INIT)
      begin
         cfg       <= fuseIn;
         clkSource <= srcOf(fuseIn);
      end
   end

   assign rcRate        = 2'(cfg.clockSourceSelect - CSRC_RC1);
   assign oscPinsAsPort = (clkSource == SRC_RC);
   assign pllSysClk     = (clkSource == SRC_PLL);
   // pll stays usable by the fast timer regardless of system source
   assign pllEnable     = pllSysClk | fastClkReq;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         extClkTick <= 1'b0;
      else
         extClkTick <= (clkSource == SRC_EXT) && (state != ST_INIT) && extSync2 && !extPrev;
   end

   // ****************************************
   // start-up sequencer
   // ****************************************
   logic [CNT_W-1:0] cnt;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_INIT;
         cnt   <= '0;
      end
      else
      begin
         case (state)
            ST_INIT:
            begin
               cnt <= delayOf(srcOf(fuseIn), fuseIn.startupTimeSelect);
               if (delayOf(srcOf(fuseIn), fuseIn.startupTimeSelect) == '0)
                  state <= ST_RUNNING;
               else
                  state <= ST_RSTDLY;
            end
            ST_RSTDLY:
            begin
               // timed from the watchdog oscillator, not the system clock
               if (wdEdge)
               begin
                  cnt <= cnt - 1'b1;
                  if (cnt == CNT_W'(1))
                     state <= ST_RUNNING;
               end
            end
            ST_RUNNING:
            begin
               if (sleepReq)
                  state <= ST_SLEEP;
            end
            ST_SLEEP:
            begin
               cnt <= startupOf(clkSource, cfg.startupTimeSelect);
               if (!sleepReq)
                  state <= ST_WAKE;
            end
            ST_WAKE:
            begin
               // mclk stands in for the source's own cycles
               cnt <= cnt - 1'b1;
               if (cnt == CNT_W'(1))
                  state <= ST_RUNNING;
            end
            default:
               state <= ST_INIT;
         endcase
      end
   end

   assign coreResetHold = (state == ST_INIT) || (state == ST_RSTDLY);
   assign clkReady      = (state == ST_RUNNING);

   // ****************************************
   // trim register
   // ****************************************
   logic apbWrite;
   logic apbSetup;
   logic mapped;

   assign apbSetup = psel & ~penable;
   assign apbWrite = psel & penable & pwrite;
   assign mapped   = (paddr == ADDR_TRIM) || (paddr == ADDR_STATUS);

   // the oscillator follows this byte directly: 00 slowest, ff fastest
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         trimValue <= TRIM_RESET;
      else if (state == ST_INIT)
         trimValue <= calibByte;
      else if (apbWrite && paddr == ADDR_TRIM)
         trimValue <= pwdata[7:0];
   end

   // ****************************************
   // apb read path
   // ****************************************
   logic [31:0] statusWord;

   always_comb
   begin
      statusWord                       = '0;
      statusWord[ST_SRC +: 2]          = clkSource;
      statusWord[ST_RATE +: 2]         = rcRate;
      statusWord[ST_PLLSEL]            = cfg.pllSystemClockSelect;
      statusWord[ST_STUP +: 2]         = cfg.startupTimeSelect;
      statusWord[ST_OSCOPT]            = cfg.oscillatorOption;
      statusWord[ST_RSVD]              = (clkSource != SRC_PLL) && (cfg.startupTimeSelect == STUP_RSVD);
      statusWord[ST_HOLD]              = coreResetHold;
      statusWord[ST_READY]             = clkReady;
      // oscillator option programmed while on rc is a configuration slip
      statusWord[ST_OPTWARN]           = oscPinsAsPort && !cfg.oscillatorOption;
      statusWord[ST_CSRC +: 4]         = cfg.clockSourceSelect;
   end

   // read data set up in the setup cycle, so no wait states are needed
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= '0;
      else if (apbSetup && !pwrite)
      begin
         if (paddr == ADDR_TRIM)
            prdata <= {24'h000000, trimValue};
         else if (paddr == ADDR_STATUS)
            prdata <= statusWord;
         else
            prdata <= '0;
      end
   end

   // zero wait states: every access completes at its first access edge
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

endmodule : scs_clock_select

// file: tb/scs_checker.sv
// port assertions for the clock source selector
// assumes it is bound onto scs_clock_select
`timescale 1ns/1ps
module scs_checker
   import scs_pkg::*;
(
   // clock, reset, bus
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // control and status
   input wire logic [7:0]        calibByte,
   input wire logic              sleepReq,
   input wire logic              fastClkReq,
   input wire scs_pkg::scs_src_t clkSource,
   input wire logic [7:0]        trimValue,
   input wire logic              oscPinsAsPort,
   input wire logic              pllEnable,
   input wire logic              pllSysClk,
   input wire logic              extClkTick,
   input wire logic              coreResetHold,
   input wire logic              clkReady
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_ready_const: assert property (pready) else $error("pready low");
   a_map_err: assert property (psel && penable |-> pslverr == !(paddr == ADDR_TRIM || paddr == ADDR_STATUS))
      else $error("pslverr wrong");
   a_pins_port: assert property (oscPinsAsPort == (clkSource == SRC_RC)) else $error("pins wrong");
   a_pll_sys: assert property (pllSysClk == (clkSource == SRC_PLL)) else $error("pll sys wrong");
   a_fast_clk: assert property (pllEnable == (pllSysClk || fastClkReq)) else $error("pll en wrong");
   a_src_held: assert property (!coreResetHold |=> $stable(clkSource)) else $error("source moved");
   a_calib_load: assert property ($rose(rst_n) |=> trimValue == calibByte) else $error("calib");
   a_trim_wr: assert property (psel && penable && pwrite && paddr == ADDR_TRIM && !coreResetHold
      |=> trimValue == $past(pwdata[7:0])) else $error("trim write");
   a_tick_ext: assert property (extClkTick |-> clkSource == SRC_EXT) else $error("tick");
   a_hold_ready: assert property (coreResetHold |-> !clkReady) else $error("ready in hold");
   a_wake_six: assert property (clkSource != SRC_PLL && !coreResetHold && !clkReady && !sleepReq
      && $past(clkReady) |=> !clkReady [*6] ##1 clkReady) else $error("wake count");
endmodule : scs_checker
bind scs_clock_select scs_checker chk_u
(
   .mclk          (mclk),
   .rst_n         (rst_n),
   .psel          (psel),
   .penable       (penable),
   .pwrite        (pwrite),
   .paddr         (paddr),
   .pwdata        (pwdata),
   .pready        (pready),
   .pslverr       (pslverr),
   .calibByte     (calibByte),
   .sleepReq      (sleepReq),
   .fastClkReq    (fastClkReq),
   .clkSource     (clkSource),
   .trimValue     (trimValue),
   .oscPinsAsPort (oscPinsAsPort),
   .pllEnable     (pllEnable),
   .pllSysClk     (pllSysClk),
   .extClkTick    (extClkTick),
   .coreResetHold (coreResetHold),
   .clkReady      (clkReady)
);

// file: tb/scs_ext_clk_model.sv
// external clock source on the osc input pin
// assumes the bench enables it only inside a window
`timescale 1ns/1ps
module scs_ext_clk_model
#(
   parameter int HALF_NS = 200
)
(
   input  wire logic en,
   output logic      clkOut
);
   // fixed period: no cycle to cycle drift; parks low when off
   initial
   begin
      clkOut = 1'b0;
      forever
      begin
         #HALF_NS;
         clkOut = en ? !clkOut : 1'b0;
      end
   end
endmodule : scs_ext_clk_model

// file: tb/testbench.sv
// self-checking bench for the clock source selector
// assumes short delay parameters 5, 9 and 20
`timescale 1ns/1ps
module testbench;
   import scs_pkg::*;
   logic        mclk, rst_n, psel, penable, pwrite, sleepReq, fastClkReq, wdogOscClk, extEn, oscInputPin, err;
   logic        pready, pslverr, oscPinsAsPort, pllEnable, pllSysClk, extClkTick, coreResetHold, clkReady;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  calibByte, trimValue;
   logic [1:0]  rcRate;
   scs_src_t    clkSource;
   scs_fuse_t   fuseIn;
   int          fails, cmp_count, seed, n, nEdge, nTick;
   scs_fuse_t   cfg [8] = '{8'h8d, 8'h93, 8'h99, 8'ha7, 8'h83, 8'h0f, 8'h09, 8'hab};

   scs_clock_select #(.STARTUP_LONG_CK(20), .DLY_SHORT_TICKS(5), .DLY_LONG_TICKS(9)) dut_u
   (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .paddr         (paddr),
      .pwdata        (pwdata),
      .prdata        (prdata),
      .pready        (pready),
      .pslverr       (pslverr),
      .fuseIn        (fuseIn),
      .calibByte     (calibByte),
      .oscInputPin   (oscInputPin),
      .wdogOscClk    (wdogOscClk),
      .sleepReq      (sleepReq),
      .fastClkReq    (fastClkReq),
      .clkSource     (clkSource),
      .rcRate        (rcRate),
      .trimValue     (trimValue),
      .oscPinsAsPort (oscPinsAsPort),
      .pllEnable     (pllEnable),
      .pllSysClk     (pllSysClk),
      .extClkTick    (extClkTick),
      .coreResetHold (coreResetHold),
      .clkReady      (clkReady)
   );
   scs_ext_clk_model ext_u (.en(extEn), .clkOut(oscInputPin));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = !mclk;
   end
   initial
   begin
      wdogOscClk = 1'b0;
      // edges at whole 100 ns steps fall on mclk falling edges and never meet an mclk rising edge
      forever #100 wdogOscClk = !wdogOscClk;
   end
   always @(posedge oscInputPin) nEdge++;
   always @(posedge mclk) if (extClkTick === 1'b1) nTick++;

   function automatic void step();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction : step

   function automatic scs_src_t esrc(scs_fuse_t f);
      if (f.pllSystemClockSelect == PLLSEL_PLL) return SRC_PLL;
      if (f.clockSourceSelect == CSRC_EXT) return SRC_EXT;
      return (f.clockSourceSelect <= CSRC_RC8) ? SRC_RC : SRC_OTHER;
   endfunction : esrc

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // no wait-state limit here: only the watchdog ends a stalled transfer
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic boot(input scs_fuse_t f);
      scs_src_t s;
      int dl, wk;
      s = esrc(f);
      dl = (s == SRC_OTHER) ? 0 : (f.startupTimeSelect == STUP_SHORT) ? 5 : (f.startupTimeSelect == STUP_LONG) ? 9 : 0;
      wk = (s != SRC_PLL) ? 6 : (f.startupTimeSelect == STUP_RSVD) ? 20 : 1024;
      step();
      @(posedge mclk);
      rst_n <= 1'b0;
      fuseIn <= f;
      calibByte <= seed[7:0];
      fastClkReq <= seed[9];
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (clkReady !== 1'b1 && n < 200);
      // free running watchdog phase: the first tick may fall early by up to one tick
      chk("delay", 1, n + 4 >= 4 * dl && n <= 4 * dl + 12);
      chk("src", s, clkSource);
      chk("trim", calibByte, trimValue);
      chk("pins", s == SRC_RC, oscPinsAsPort);
      chk("pll sys", s == SRC_PLL, pllSysClk);
      chk("pll en", (s == SRC_PLL) || fastClkReq, pllEnable);
      chk("hold", 0, coreResetHold);
      if (s == SRC_RC) chk("rate", f.clockSourceSelect - 1, rcRate);
      @(posedge mclk);
      fuseIn <= ~f;
      sleepReq <= 1'b1;
      @(posedge mclk);
      sleepReq <= 1'b0;
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (clkReady !== 1'b1 && n < 2000);
      chk("wake", wk + 2, n);
      step();
      apb(1'b1, ADDR_TRIM, seed);
      apb(1'b0, ADDR_TRIM, 32'h0);
      chk("trim rw", {24'h0, seed[7:0]}, rd);
      apb(1'b1, ADDR_STATUS, 32'hffffffff);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status", {16'h0, f.clockSourceSelect, 10'h0, s}, rd & 32'hf003);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      nEdge = 0;
      nTick = 0;
      extEn <= 1'b1;
      repeat (40) @(posedge mclk);
      extEn <= 1'b0;
      repeat (12) @(posedge mclk);
      chk("ticks", (s == SRC_EXT) ? nEdge : 0, nTick);
   endtask : boot

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      #1000000;
      fails++;
      final_report();
   end

   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sleepReq = 1'b0;
      fastClkReq = 1'b0;
      extEn = 1'b0;
      fuseIn = cfg[0];
      calibByte = 8'h00;
      seed = 35;
      fails = 0;
      cmp_count = 0;
      foreach (cfg[i]) boot(cfg[i]);
      final_report();
   end
endmodule : testbench
